/* File: shared/pfs_pkg.sv */
// Package for the power-stage fault supervisor.
// Assumes a 250 MHz logic clock and an AXI4-Lite master with 32-bit data.
package pfs_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 250;
    localparam int SC_MS_PER_UF = 15;
    localparam int SC_CYC_PER_UF = SC_MS_PER_UF * CLK_MHZ * 1000;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PKG_BIT = 2;
    localparam int CTRL_CAP_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_THERM_BIT = 4;
    localparam int ST_UV_BIT = 5;
    localparam int ST_OLP_LSB = 8;
    localparam int ST_SHORT_BIT = 12;
    localparam int ST_READY_BIT = 13;
    localparam int ST_SD_BIT = 14;
    localparam int ST_ON_LSB = 16;
    localparam int ST_TEMP_LSB = 20;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        MODE_BRIDGED = 2'b00,
        MODE_PARALLEL = 2'b01,
        MODE_SINGLE = 2'b10
    } pfs_mode_e;

    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_CHK_GND = 2'b01,
        ST_CHK_SUP = 2'b10,
        ST_RUN = 2'b11
    } pfs_state_e;

    // Comparator and pin levels arriving from outside the clock domain
    typedef struct packed {
        logic ctrlReset_n;
        logic commonSupplyOk;
        logic [3:0] gateDriveSupplyOk;
        logic [3:0] bootstrapOk;
        logic temp100;
        logic temp125;
        logic temp155;
        logic [3:0] shortToGnd;
        logic [3:0] shortToStageSupply;
        logic [3:0] overcurrent;
        logic [3:0] overload;
        logic nearSat;
    } pfs_sense_s;

    // Half-bridge drive controls
    typedef struct packed {
        logic [3:0] switchEn;
        logic [3:0] weakPulldown;
    } pfs_drive_s;

endpackage

/* File: rtl/pfs_fault_supervisor.sv */
// Fault supervisor of a four-half-bridge power stage with AXI4-Lite registers.
// Assumes analog comparators deliver levels asynchronously; open-drain pins are
// resolved outside from the output enables.
// How it works
// R1: Errors switch off mode-defined half-bridge groups.
// R2: Bootstrap undervoltage stops only its half-bridge.
// R3: Short check runs once at supply start.
// R4: Found short holds Hi-Z until removed.
// R5: Check ground shorts first, then supply shorts.
// R6: Check length scales with filter capacitance.
// R7: During check hold fault low, ignore reset; a reset rising edge still clears overload.
// R8: Clean check releases the fault output.
// R9: Reset pulse never restarts the short check.
// R10: Short check skipped in single-ended mode.
// R11: Quad-flat variant warns at 100 and 125.
// R12: Small-outline variant warns only at 125.
// R13: Over 155 degrees: Hi-Z all, fault low.
// R14: Thermal shutdown latched until reset pin asserted.
// R15: Power-on clears overload, waits for supplies.
// R16: Supply undervoltage: all Hi-Z, fault low.
// R17: Undervoltage recovery is automatic without reset.
// R18: Reset low: Hi-Z, pulldowns in bridged modes.
// R19: Reset low forces fault output released.
// R20: Reset rising edge clears overload, restarts.
// R21: Controller waits 4 ms after fault edge.
// R22: Ready drops on overcurrent.
// R23: Any shutdown fault drives fault output low.
// R24: Other faults recover once condition clears.
// R25: Controller counts hold-off with own clock.
`timescale 1ns/1ps
module pfs_fault_supervisor
    import pfs_pkg::*;
#(
    parameter int CYC_PER_UF = SC_CYC_PER_UF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous sense levels
    input wire pfs_sense_s sense,
    // Half-bridge drive
    output pfs_drive_s drive,
    // Open-drain status pins, enable high while pulling low
    output logic shutdownFaultOut,
    output logic shutdownFaultOe,
    output logic tempWarnLowOut,
    output logic tempWarnLowOe,
    output logic tempWarnHighOut,
    output logic tempWarnHighOe,
    // Indications
    output logic ready,
    output logic nearSaturationFlag
);

    localparam int SW = $bits(pfs_sense_s);
    // Reset pin sits in its idle high level so no false reset edge follows rst_b
    localparam logic [SW-1:0] SENSE_IDLE = {1'b1, {(SW-1){1'b0}}};

    // Two-stage synchroniser for every outside level
    logic [SW-1:0] senseMeta;
    logic [SW-1:0] senseSync;
    pfs_sense_s s;
    assign s = pfs_sense_s'(senseSync);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            senseMeta <= SENSE_IDLE;
            senseSync <= SENSE_IDLE;
        end else begin
            senseMeta <= sense;
            senseSync <= senseMeta;
        end
    end

    // Registers
    logic [31:0] ctrl;
    pfs_state_e state;
    pfs_state_e next_state;
    logic [31:0] stepCnt;
    logic thermLatch;
    logic [3:0] olpLatch;
    logic resetPinQ;
    logic shortSeen;

    wire pfs_mode_e mode = pfs_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
    wire smallOutline = ctrl[CTRL_PKG_BIT];
    wire [7:0] capUf = ctrl[CTRL_CAP_LSB +: 8];
    wire [7:0] capEff = (capUf == 8'h00) ? 8'h01 : capUf;
    // Each of the two steps gets half the per-microfarad budget
    wire [31:0] stepLimit = 32'(capEff) * 32'(CYC_PER_UF / 2); // R6

    wire resetPin_n = s.ctrlReset_n;
    wire resetRise = resetPin_n & ~resetPinQ;
    wire checking = (state == ST_CHK_GND) || (state == ST_CHK_SUP);
    wire supplyOk = s.commonSupplyOk & (&s.gateDriveSupplyOk);
    wire underVolt = ~supplyOk; // R16 R17
    // Reset pin low level has no effect while the check runs; its rising edge still clears overload
    wire resetHeld = ~resetPin_n & ~checking; // R7 R18
    wire stepDone = (stepCnt >= stepLimit);
    wire shortNow = (state == ST_CHK_GND) ? |s.shortToGnd : |s.shortToStageSupply;

    // Start-up sequence; leaving ST_RUN only happens through the logic reset
    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (supplyOk) begin // R15
                    next_state = (mode == MODE_SINGLE) ? ST_RUN : ST_CHK_GND; // R3 R10
                end
            end
            ST_CHK_GND: begin
                if (stepDone && !shortNow) begin
                    next_state = ST_CHK_SUP; // R5
                end
            end
            ST_CHK_SUP: begin
                if (stepDone && !shortNow) begin
                    next_state = ST_RUN; // R4 R8
                end
            end
            ST_RUN: next_state = ST_RUN; // R9
            default: next_state = ST_POR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= ST_POR;
            stepCnt <= '0;
            shortSeen <= 1'b0;
        end else begin
            state <= next_state;
            // A present short restarts the settling count of the step
            if (!checking || next_state != state || shortNow) begin // R4
                stepCnt <= '0;
            end else begin
                stepCnt <= stepCnt + 32'h0000_0001;
            end
            if (checking && shortNow) begin
                shortSeen <= 1'b1;
            end
        end
    end

    // Latched faults: set wins over the reset-pin clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            thermLatch <= 1'b0;
            olpLatch <= '0; // R15
            resetPinQ <= 1'b1;
        end else begin
            resetPinQ <= resetPin_n;
            thermLatch <= (thermLatch & ~resetHeld) | s.temp155; // R13 R14
            olpLatch <= (olpLatch & ~{4{resetHeld | resetRise}}) | s.overload; // R20
        end
    end

    // Half-bridge grouping of local errors
    wire [3:0] localErr = olpLatch | s.overcurrent; // R24
    wire pairAB = localErr[0] | localErr[1];
    wire pairCD = localErr[2] | localErr[3];
    wire [3:0] groupOff = (mode == MODE_PARALLEL) ? {4{|localErr}} :
                          {pairCD, pairCD, pairAB, pairAB}; // R1
    wire globalOff = thermLatch | underVolt | (state != ST_RUN) | ~resetPin_n; // R13 R16 R18
    wire [3:0] next_switchEn = ~groupOff & s.bootstrapOk & {4{~globalOff}}; // R2
    wire [3:0] next_pulldown = {4{resetHeld & (mode != MODE_SINGLE)}}; // R18

    wire anyFault = thermLatch | underVolt | (|olpLatch) | (state == ST_POR);
    // Fault pin pulled low during the check or on a shutdown fault
    wire next_sdLow = checking | (anyFault & resetPin_n); // R7 R19 R23
    wire next_ready = (state == ST_RUN) & ~(|s.overcurrent) & ~globalOff & ~(|olpLatch); // R22
    wire next_warnLow = ~smallOutline & s.temp100; // R11
    wire next_warnHigh = s.temp125; // R11 R12

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            drive <= '0;
            shutdownFaultOe <= 1'b1;
            tempWarnLowOe <= 1'b0;
            tempWarnHighOe <= 1'b0;
            ready <= 1'b0;
            nearSaturationFlag <= 1'b0;
        end else begin
            drive.switchEn <= next_switchEn;
            drive.weakPulldown <= next_pulldown;
            shutdownFaultOe <= next_sdLow;
            tempWarnLowOe <= next_warnLow;
            tempWarnHighOe <= next_warnHigh;
            ready <= next_ready;
            nearSaturationFlag <= s.nearSat;
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge ref_clk) begin
        shutdownFaultOut <= 1'b0;
        tempWarnLowOut <= 1'b0;
        tempWarnHighOut <= 1'b0;
    end

    // AXI4-Lite write channel: address and data taken in either order
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;

    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire wrHitCtrl = (awAddr == REG_CTRL);
    wire wrHitStatus = (awAddr == REG_STATUS);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl <= CTRL_RESET;
        end else begin
            s_axi_awready <= ~awHeld & ~awTake & ~s_axi_awready;
            s_axi_wready <= ~wHeld & ~wTake & ~s_axi_wready;
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrHitCtrl | wrHitStatus) ? RESP_OKAY : RESP_DECERR;
                if (wrHitCtrl) begin
                    for (int i = 0; i < 4; i++) begin
                        if (wStrb[i]) begin
                            ctrl[i*8 +: 8] <= wData[i*8 +: 8];
                        end
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    wire [31:0] ctrlView = {16'h0000, ctrl[CTRL_CAP_LSB +: 8], 5'h00, ctrl[2:0]};
    wire [31:0] statusView = (32'(state) << ST_STATE_LSB)
                           | (32'(thermLatch) << ST_THERM_BIT)
                           | (32'(underVolt) << ST_UV_BIT)
                           | (32'(olpLatch) << ST_OLP_LSB)
                           | (32'(shortSeen) << ST_SHORT_BIT)
                           | (32'(ready) << ST_READY_BIT)
                           | (32'(shutdownFaultOe) << ST_SD_BIT)
                           | (32'(drive.switchEn) << ST_ON_LSB)
                           | (32'({s.temp155, s.temp125, s.temp100}) << ST_TEMP_LSB);
    wire rdHitCtrl = (s_axi_araddr == REG_CTRL);
    wire rdHitStatus = (s_axi_araddr == REG_STATUS);
    wire [31:0] rdMux = rdHitCtrl ? ctrlView : (rdHitStatus ? statusView : 32'h0000_0000);
    wire arTake = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~arTake & ~s_axi_arready;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= (rdHitCtrl | rdHitStatus) ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: test/pfs_fault_asserts.sv */
// Pin-level checks for the fault supervisor.
// Assumes sense levels reach the outputs within four clocks when they pass a fault latch.
`timescale 1ns/1ps
module pfs_fault_asserts
    import pfs_pkg::*;
#(
    parameter int CYC_PER_UF = SC_CYC_PER_UF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Watched ports
    input wire pfs_sense_s sense,
    input wire pfs_drive_s drive,
    input wire logic shutdownFaultOe,
    input wire logic tempWarnLowOe,
    input wire logic tempWarnHighOe,
    input wire logic ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Five samples cover the synchroniser and the output flop
    AST_GROUP_AB:
    assert property (sense.overload[0] [*5] |-> drive.switchEn[1:0] == 2'b00) else $error("pair A B still on");
    AST_BOOT_LOCAL:
    assert property ((!sense.bootstrapOk[0]) [*5] |-> !drive.switchEn[0]) else $error("A still on");
    AST_THERM_OFF:
    assert property ((sense.temp155 && sense.ctrlReset_n) [*5] |-> drive.switchEn == 4'h0 && shutdownFaultOe)
        else $error("hot stage not off");
    AST_UV_OFF:
    assert property ((!sense.commonSupplyOk && sense.ctrlReset_n) [*5] |-> drive.switchEn == 4'h0 && shutdownFaultOe)
        else $error("low supply stage not off");
    AST_PIN_HIZ:
    assert property ((!sense.ctrlReset_n) [*5] |-> drive.switchEn == 4'h0) else $error("switching in reset");
    AST_PD_OFF:
    assert property (sense.ctrlReset_n [*5] |-> drive.weakPulldown == 4'h0) else $error("pulldown outside reset");
    AST_OC_READY:
    assert property ((sense.overcurrent != 4'h0) [*5] |-> !ready) else $error("ready during overcurrent");
    AST_WARN_HIGH:
    assert property ($stable(sense.temp125) [*5] |-> tempWarnHighOe == sense.temp125) else $error("high warning");
    AST_WARN_LOW:
    assert property ((!sense.temp100) [*5] |-> !tempWarnLowOe) else $error("low warning while cool");
endmodule

/* File: test/pfs_ctrl_model.sv */
// Controller model on the far side: drives the reset pin when the bench asks.
// Assumes faultPin is the resolved open-drain level with its pull-up.
`timescale 1ns/1ps
module pfs_ctrl_model #(
    parameter int HOLD = 16
) (
    // Clock
    input wire logic ref_clk,
    // Pins and request
    input wire logic faultPin,
    input wire logic resetHold,
    output logic ctrlReset_n = 1'b1
);
    // HOLD stands for the scaled-down hold-off; the release waits for it
    int sinceFall = 0;
    logic lastPin = 1'b1;
    always @(posedge ref_clk) begin
        lastPin <= faultPin;
        if (lastPin && !faultPin)
            sinceFall <= 0;
        else if (sinceFall < HOLD)
            sinceFall <= sinceFall + 1;
        if (resetHold)
            ctrlReset_n <= 1'b0;
        else if (sinceFall >= HOLD)
            ctrlReset_n <= 1'b1;
    end
endmodule

/* File: test/power_stage_fault_supervisor_tb_top.sv */
// Self-checking bench: bus tasks, controller model on the reset pin, group model.
// Assumes CYC_PER_UF shortened so a check step is 20 clocks.
`timescale 1ns/1ps
module power_stage_fault_supervisor_tb_top;
    import pfs_pkg::*;
    localparam int CYC_PER_UF = 40;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic resetHold = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ctrlRstN;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic shutdownFaultOe, tempWarnLowOe, tempWarnHighOe, ready, nearFlag;
    pfs_sense_s senseTb;
    pfs_sense_s senseIn;
    pfs_drive_s drive;
    pfs_mode_e md[3] = '{MODE_SINGLE, MODE_PARALLEL, MODE_BRIDGED};
    int nMismatch = 0;
    int testsRun = 0;

    always #2 ref_clk = ~ref_clk;
    always_comb begin
        senseIn = senseTb;
        senseIn.ctrlReset_n = ctrlRstN;
    end

    pfs_fault_supervisor #(.CYC_PER_UF(CYC_PER_UF)) uut (
        .ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense(senseIn), .drive, .shutdownFaultOut(),
        .shutdownFaultOe, .tempWarnLowOut(), .tempWarnLowOe, .tempWarnHighOut(), .tempWarnHighOe, .ready,
        .nearSaturationFlag(nearFlag)
    );
    // Pull-up turns the enable into the pin level
    pfs_ctrl_model #(.HOLD(16)) peer (.ref_clk, .faultPin(!shutdownFaultOe), .resetHold, .ctrlReset_n(ctrlRstN));

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        testsRun++;
        if (got !== want) begin
            nMismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Waits for the answer as long as it takes; only the watchdog ends a hang
    task automatic axw(input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= REG_CTRL;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, RESP_OKAY);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic waitSt(input logic [1:0] v);
        logic [31:0] s;
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            axr(REG_STATUS, s, r);
            n++;
        end while (s[1:0] !== v && n < 100);
        chk(s[1:0], v);
    endtask
    // Reset pin pulse through the controller model
    task automatic rp(input pfs_mode_e m);
        resetHold <= 1'b1;
        tick(8);
        chk({drive.switchEn, drive.weakPulldown}, {4'h0, m == MODE_SINGLE ? 4'h0 : 4'hF});
        chk(shutdownFaultOe, 1'b0);
        resetHold <= 1'b0;
        tick(30);
    endtask
    task automatic boot(input pfs_mode_e m);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        k = $urandom % 4;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        senseTb.commonSupplyOk <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        axr(REG_CTRL, d, r);
        chk(d, CTRL_RESET);
        axr(8'h08, d, r);
        chk({r, d[7:0]}, {RESP_DECERR, 8'h00});
        axw({16'h0, 8'h01, 6'h0, m});
        axr(REG_STATUS, d, r);
        chk({shutdownFaultOe, d[1:0], drive.switchEn}, {1'b1, ST_POR, 4'h0});
        if (m == MODE_SINGLE) begin
            senseTb.commonSupplyOk <= 1'b1;
            tick(8);
            waitSt(ST_RUN);
        end else begin
            senseTb.commonSupplyOk <= 1'b1;
            senseTb.shortToGnd[k] <= 1'b1;
            resetHold <= 1'b1;
            tick(60);
            axr(REG_STATUS, d, r);
            chk({shutdownFaultOe, d[1:0], drive}, {1'b1, ST_CHK_GND, 8'h00});
            senseTb.shortToGnd[k] <= 1'b0;
            resetHold <= 1'b0;
            waitSt(ST_CHK_SUP);
            waitSt(ST_RUN);
            axr(REG_STATUS, d, r);
            chk({shutdownFaultOe, d[ST_SHORT_BIT]}, 2'b01);
        end
        tick(30);
        chk({ready, drive.switchEn}, 5'h1F);
        senseTb.shortToStageSupply[k] <= 1'b1;
        tick(8);
        axr(REG_STATUS, d, r);
        chk({d[1:0], drive.switchEn}, {ST_RUN, 4'hF});
        senseTb.shortToStageSupply[k] <= 1'b0;
    endtask
    task automatic runTests(input pfs_mode_e m);
        logic [3:0] on;
        logic so;
        int k;
        k = $urandom % 4;
        so = (m == MODE_SINGLE);
        on = m == MODE_PARALLEL ? 4'h0 : (k < 2 ? 4'hC : 4'h3);
        senseTb.overload[k] <= 1'b1;
        tick(8);
        chk({shutdownFaultOe, drive.switchEn}, {1'b1, on});
        senseTb.overload[k] <= 1'b0;
        tick(8);
        chk(drive.switchEn, on);
        rp(m);
        waitSt(ST_RUN);
        chk(drive.switchEn, 4'hF);
        // Bootstrap fault sits in the other pair so its own effect is visible outside parallel mode
        senseTb.bootstrapOk[k ^ 2] <= 1'b0;
        senseTb.overcurrent[k] <= 1'b1;
        senseTb.nearSat <= 1'b1;
        tick(8);
        chk({ready, drive.switchEn, nearFlag}, {1'b0, on & ~(4'h1 << (k ^ 2)), 1'b1});
        senseTb.bootstrapOk[k ^ 2] <= 1'b1;
        senseTb.overcurrent[k] <= 1'b0;
        senseTb.nearSat <= 1'b0;
        tick(8);
        chk({ready, drive.switchEn, nearFlag}, 6'h3E);
        axw({16'h0, 8'h01, 5'h0, so, m});
        senseTb.temp100 <= 1'b1;
        tick(8);
        chk({tempWarnHighOe, tempWarnLowOe}, {1'b0, !so});
        senseTb.temp125 <= 1'b1;
        tick(8);
        chk({tempWarnHighOe, tempWarnLowOe}, {1'b1, !so});
        senseTb.temp155 <= 1'b1;
        tick(8);
        chk({shutdownFaultOe, drive.switchEn}, 5'h10);
        senseTb.temp155 <= 1'b0;
        senseTb.temp125 <= 1'b0;
        senseTb.temp100 <= 1'b0;
        tick(8);
        chk({shutdownFaultOe, drive.switchEn}, 5'h10);
        rp(m);
        chk(drive.switchEn, 4'hF);
        senseTb.gateDriveSupplyOk[k] <= 1'b0;
        tick(8);
        chk({shutdownFaultOe, drive.switchEn}, 5'h10);
        senseTb.gateDriveSupplyOk[k] <= 1'b1;
        tick(8);
        chk({shutdownFaultOe, drive.switchEn}, 5'h0F);
    endtask
    task automatic conclude();
        if (nMismatch == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(25));
        senseTb = '0;
        senseTb.gateDriveSupplyOk = 4'hF;
        senseTb.bootstrapOk = 4'hF;
        for (int i = 0; i < 3; i++) begin
            boot(md[i]);
            runTests(md[i]);
        end
        conclude();
    end
    initial begin
        #100000;
        nMismatch++;
        conclude();
    end
endmodule

bind pfs_fault_supervisor pfs_fault_asserts #(.CYC_PER_UF(CYC_PER_UF)) chkr (
    .ref_clk, .rst_b, .sense, .drive, .shutdownFaultOe, .tempWarnLowOe, .tempWarnHighOe, .ready
);
